// file: verilog/wkd_pkg.sv
// wkd_pkg: constants, field layout and types of the wake input detection block.
// assumes a single 40 MHz clock and an APB register port with 8-bit byte addresses.
`default_nettype none
package wkd_pkg;

	// clock and filter timing
	localparam int WKD_CLK_MHZ          = 40;
	localparam int WKD_SHORT_FILTER_NS  = 16000;
	localparam int WKD_LONG_FILTER_NS   = 64000;
	// least times, rounded up to whole cycles
	localparam int WKD_SHORT_CYC = (WKD_SHORT_FILTER_NS * WKD_CLK_MHZ + 999) / 1000;
	localparam int WKD_LONG_CYC  = (WKD_LONG_FILTER_NS * WKD_CLK_MHZ + 999) / 1000;

	// register byte offsets
	localparam logic [7:0] WKD_OFF_WAKE_EN   = 8'h00; // wake_enable_control
	localparam logic [7:0] WKD_OFF_PULL      = 8'h04; // pull_current_control
	localparam logic [7:0] WKD_OFF_FILT      = 8'h08; // detect_filter_control
	localparam logic [7:0] WKD_OFF_SRC_STAT  = 8'h0c; // wake_source_status
	localparam logic [7:0] WKD_OFF_ALT_STAT  = 8'h10; // alt_pin_wake_status
	localparam logic [7:0] WKD_OFF_LVL_STAT  = 8'h14; // wake_pin_level_status

	// field positions in wake_enable_control
	localparam int WKD_EN_LSB   = 0; // three per-input enables
	localparam int WKD_MEAS_BIT = 3; // measure_enable
	localparam int WKD_FO_LSB   = 4; // two fail-output wake enables
	localparam int WKD_CTRL_W   = 6;

	// reset values
	localparam logic [5:0] WKD_CTRL_RST = 6'h00;
	localparam logic [5:0] WKD_PULL_RST = 6'h00;
	localparam logic [5:0] WKD_FILT_RST = 6'h00;

	// pull_select_high_bit / pull_select_low_bit codes
	localparam logic [1:0] WKD_PULL_NONE = 2'h0;
	localparam logic [1:0] WKD_PULL_DOWN = 2'h1;
	localparam logic [1:0] WKD_PULL_UP   = 2'h2;
	localparam logic [1:0] WKD_PULL_AUTO = 2'h3;

	// filter_select_high_bit / filter_select_low_bit codes
	localparam logic [1:0] WKD_FLT_STATIC_SHORT = 2'h0;
	localparam logic [1:0] WKD_FLT_STATIC_LONG  = 2'h1;
	localparam logic [1:0] WKD_FLT_CYCLIC_T1    = 2'h2;
	localparam logic [1:0] WKD_FLT_CYCLIC_T2    = 2'h3;

	typedef enum logic [1:0] {
		WKD_NORMAL   = 2'b00,
		WKD_STOP     = 2'b01,
		WKD_SLEEP    = 2'b10,
		WKD_FAILSAFE = 2'b11
	} wkd_mode_t;

endpackage
`default_nettype wire

// file: verilog/wkd_filt_if.sv
// wkd_filt_if: configuration into and results out of one input filter.
// assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface wkd_filt_if;
	logic long_sel;   // 64 us instead of 16 us
	logic cyclic;     // cyclic sense, evaluate only in window
	logic window_on;  // cyclic sense active window
	logic level;      // synchronised present level
	logic filt_level; // filtered (sampled) level
	logic evt;        // one-cycle pulse per recognised edge
	modport filt (input long_sel, cyclic, window_on, output level, filt_level, evt);
	modport ctl  (output long_sel, cyclic, window_on, input level, filt_level, evt);
endinterface
`default_nettype wire

// file: verilog/wkd_filter.sv
// wkd_filter: three-flop synchroniser and glitch filter for one wake pin.
// assumes pin is asynchronous; configuration comes from logic on clk.
`timescale 1ns/1ps
`default_nettype none
module wkd_filter
	import wkd_pkg::*;
#(
	parameter int SHORT_CYC = WKD_SHORT_CYC,
	parameter int LONG_CYC  = WKD_LONG_CYC
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	wkd_filt_if.filt  fi
);
	localparam int CW = $clog2(LONG_CYC + 1);
	localparam logic [CW-1:0] LIM_S = CW'(SHORT_CYC - 1);
	localparam logic [CW-1:0] LIM_L = CW'(LONG_CYC - 1);

	if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin : g_chk
		$error("wkd_filter: filter counts out of range");
	end

	logic [2:0]    sync_r, sync_nxt;
	logic          agreed_r, agreed_nxt;
	logic          stable_r, stable_nxt;
	logic          evt_r, evt_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [CW-1:0] limit;
	logic          window;

	// stage 0 feeds stage 1 only; a change counts once stages 1 and 2 agree
	always_comb begin
		sync_nxt   = {sync_r[1:0], pin};
		agreed_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : agreed_r;
		limit      = fi.long_sel ? LIM_L : LIM_S;
		window     = ~fi.cyclic | fi.window_on;
		stable_nxt = stable_r;
		evt_nxt    = 1'b0;
		if (agreed_nxt != agreed_r) begin
			cnt_nxt = '0;
		end else if (!window) begin
			cnt_nxt = '0;
		end else if (cnt_r < limit) begin
			cnt_nxt = cnt_r + 1'b1;
		end else begin
			cnt_nxt = limit; // clamp, a long-to-short switch must not wrap the count
		end
		// both directions count, a re-crossing before the limit is dropped
		if (window && agreed_nxt == agreed_r && cnt_r == limit && agreed_r != stable_r) begin
			stable_nxt = agreed_r;
			evt_nxt    = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sync_r   <= 3'h0;
			agreed_r <= 1'b0;
			stable_r <= 1'b0;
			evt_r    <= 1'b0;
			cnt_r    <= '0;
		end else begin
			sync_r   <= sync_nxt;
			agreed_r <= agreed_nxt;
			stable_r <= stable_nxt;
			evt_r    <= evt_nxt;
			cnt_r    <= cnt_nxt;
		end
	end

	assign fi.level      = agreed_r;
	assign fi.filt_level = stable_r;
	assign fi.evt        = evt_r;

	// a recognised edge needs a full quiet interval before it
	filt_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
		evt_nxt |-> cnt_r == limit && agreed_nxt == agreed_r)
		else $error("edge recognised before filter interval elapsed");
	filt_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
		agreed_nxt != agreed_r |=> cnt_r == '0)
		else $error("filter count not restarted on crossing");
	filt_rise_c: cover property (@(posedge clk) disable iff (!rst_n) evt_r && stable_r);
	filt_fall_c: cover property (@(posedge clk) disable iff (!rst_n) evt_r && !stable_r);

endmodule // wkd_filter
`default_nettype wire

// file: verilog/wkd_top.sv
// wkd_top: wake input detection with APB registers, filters, pulls and measurement switch.
// assumes mode, sleep command and cyclic timer windows come from logic on pclk.
// Notes on behaviour
// - both rising and falling threshold crossings on a wake input give an event.
// - events interrupt in normal or stop mode, wake the chip in sleep or fail-safe.
// - per input, static sense watches always; cyclic sense only inside timer window.
// - filter field 00/01 static 16/64 us, 10/11 cyclic timer one/two 16 us.
// - crossing starts filter; event only if no re-crossing before interval ends.
// - per-input enable bits in the wake control register allow wake-up.
// - per-input wake source bits record which input woke; readable anytime.
// - level status shows each input's level in normal and stop, enabled or not.
// - in cyclic sense the level bit holds the level sampled in last window.
// - fail-output pins as wake inputs use fixed 16 us static, alternate status.
// - pull field 00 none (reset), 01 pull-down, 10 pull-up, 11 automatic.
// - automatic mode pulls up while level high, pulls down while level low.
// - measurement switch works only in normal mode; replaces inputs one/two signalling.
// - active measurement closes the switch routing input one out through input two.
// - measurement is off at reset, enabled only by setting its enable bit.
// - measurement disables pulls of inputs one/two, gates them, freezes their status.
// - sleep command with measurement and only inputs one/two enabled: serial fail, restart.
`timescale 1ns/1ps
`default_nettype none
module wkd_top
	import wkd_pkg::*;
#(
	parameter int SHORT_CYC = WKD_SHORT_CYC,
	parameter int LONG_CYC  = WKD_LONG_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        wake_input_one,
	input  wire logic        wake_input_two,
	input  wire logic        wake_input_three,
	input  wire logic [1:0]  fail_outputs_two_three,
	input  wire wkd_mode_t   sbc_mode,
	input  wire logic        sleep_cmd,
	input  wire logic        timer_one_on,
	input  wire logic        timer_two_on,
	output logic             wake_irq,
	output logic             wake_up_req,
	output logic             serial_fail_set,
	output logic             restart_req,
	output logic      [2:0]  pull_up_en,
	output logic      [2:0]  pull_down_en,
	output logic             measure_switch_close
);
	if (SHORT_CYC < 1 || LONG_CYC < SHORT_CYC) begin : g_chk
		$error("wkd_top: filter counts out of range");
	end

	// register state
	logic [WKD_CTRL_W-1:0] ctrl_r, ctrl_nxt;
	logic [5:0]  pull_r, pull_nxt;
	logic [5:0]  filt_r, filt_nxt;
	logic [2:0]  src_r, src_nxt;
	logic [1:0]  alt_r, alt_nxt;
	logic [2:0]  lvl_r, lvl_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic        pready_r, pready_nxt;
	logic        pslverr_r, pslverr_nxt;

	// output state
	logic        irq_r, irq_nxt;
	logic        wup_r, wup_nxt;
	logic        sfail_r, sfail_nxt;
	logic        rst_req_r, rst_req_nxt;
	logic [2:0]  pu_r, pu_nxt;
	logic [2:0]  pd_r, pd_nxt;
	logic        sw_r, sw_nxt;

	// shared combinational terms
	logic        acc, wr;
	logic        mapped;
	logic [2:0]  wake_en;
	logic [1:0]  fo_en;
	logic        meas;
	logic        mode_awake;
	logic [2:0]  meas_gate;
	logic [4:0]  pins, evt, lvl, flv;
	logic [2:0]  cyc;
	logic [2:0]  src_set, src_clr, src_keep;
	logic [1:0]  alt_set, alt_clr;
	logic        bad_sleep;

	assign wake_en    = ctrl_r[WKD_EN_LSB +: 3];
	assign fo_en      = ctrl_r[WKD_FO_LSB +: 2];
	assign meas       = ctrl_r[WKD_MEAS_BIT];
	assign mode_awake = (sbc_mode == WKD_NORMAL) || (sbc_mode == WKD_STOP);
	assign meas_gate  = {1'b0, meas, meas};
	assign pins       = {fail_outputs_two_three, wake_input_three, wake_input_two,
		wake_input_one};

	// one filter per pin; fail-output pins are fixed to the 16 us static filter
	for (genvar i = 0; i < 5; i++) begin : g_pin
		wkd_filt_if fif ();
		if (i < 3) begin : g_wk
			assign fif.long_sel  = filt_r[2*i +: 2] == WKD_FLT_STATIC_LONG;
			assign fif.cyclic    = filt_r[2*i+1];
			// the window only means something if the timer also powers the sensor
			assign fif.window_on = filt_r[2*i] ? timer_two_on : timer_one_on;
			assign cyc[i]        = filt_r[2*i+1];
		end else begin : g_fo
			assign fif.long_sel  = 1'b0;
			assign fif.cyclic    = 1'b0;
			assign fif.window_on = 1'b1;
		end
		assign evt[i] = fif.evt;
		assign lvl[i] = fif.level;
		assign flv[i] = fif.filt_level;
		wkd_filter #(
			.SHORT_CYC (SHORT_CYC),
			.LONG_CYC  (LONG_CYC)
		) u_filt (
			.clk   (pclk),
			.rst_n (presetn),
			.pin   (pins[i]),
			.fi    (fif)
		);
	end

	// apb: one wait state, so pready and read data leave a flop
	assign acc = psel & penable & pready_r;
	assign wr  = acc & pwrite;

	always_comb begin
		mapped = 1'b1;
		unique case (paddr)
			WKD_OFF_WAKE_EN:  prdata_nxt = {26'h000_0000, ctrl_r};
			WKD_OFF_PULL:     prdata_nxt = {26'h000_0000, pull_r};
			WKD_OFF_FILT:     prdata_nxt = {26'h000_0000, filt_r};
			WKD_OFF_SRC_STAT: prdata_nxt = {29'h0000_0000, src_r};
			WKD_OFF_ALT_STAT: prdata_nxt = {30'h0000_0000, alt_r};
			WKD_OFF_LVL_STAT: prdata_nxt = {29'h0000_0000, lvl_r};
			default: begin
				prdata_nxt = 32'h0000_0000;
				mapped     = 1'b0;
			end
		endcase
		pready_nxt  = psel & penable & ~pready_r;
		pslverr_nxt = pready_nxt & ~mapped;
		if (!pready_nxt || pwrite) begin
			prdata_nxt = prdata_r;
		end
		// control registers; settings for inputs one/two may change while gated
		ctrl_nxt = ctrl_r;
		pull_nxt = pull_r;
		filt_nxt = filt_r;
		if (wr && paddr == WKD_OFF_WAKE_EN) begin
			ctrl_nxt = pwdata[WKD_CTRL_W-1:0];
		end
		if (wr && paddr == WKD_OFF_PULL) begin
			pull_nxt = pwdata[5:0];
		end
		if (wr && paddr == WKD_OFF_FILT) begin
			filt_nxt = pwdata[5:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= 32'h0000_0000;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			ctrl_r    <= WKD_CTRL_RST;
			pull_r    <= WKD_PULL_RST;
			filt_r    <= WKD_FILT_RST;
		end else begin
			prdata_r  <= prdata_nxt;
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			ctrl_r    <= ctrl_nxt;
			pull_r    <= pull_nxt;
			filt_r    <= filt_nxt;
		end
	end

	// status: write one to clear, a set in the same cycle wins
	always_comb begin
		src_set  = evt[2:0] & wake_en & ~meas_gate;
		alt_set  = evt[4:3] & fo_en;
		src_clr  = (wr && paddr == WKD_OFF_SRC_STAT) ? pwdata[2:0] : 3'h0;
		alt_clr  = (wr && paddr == WKD_OFF_ALT_STAT) ? pwdata[1:0] : 2'h0;
		src_keep = src_r & ~src_clr;
		src_nxt  = src_keep | src_set;
		alt_nxt  = (alt_r & ~alt_clr) | alt_set;
		lvl_nxt  = lvl_r;
		for (int i = 0; i < 3; i++) begin
			// frozen outside normal/stop and for gated inputs
			if (mode_awake && !meas_gate[i]) begin
				lvl_nxt[i] = cyc[i] ? flv[i] : lvl[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_r <= 3'h0;
			alt_r <= 2'h0;
			lvl_r <= 3'h0;
		end else begin
			src_r <= src_nxt;
			alt_r <= alt_nxt;
			lvl_r <= lvl_nxt;
		end
	end

	// signalling, pull sources and measurement switch
	always_comb begin
		irq_nxt     = (|src_set || |alt_set) && mode_awake;
		wup_nxt     = (|src_set || |alt_set) && !mode_awake;
		// only inputs one/two would wake us, but measurement gates them
		bad_sleep   = meas && !wake_en[2] && fo_en == 2'h0 && wake_en[1:0] != 2'h0;
		sfail_nxt   = sleep_cmd && bad_sleep;
		rst_req_nxt = sleep_cmd && bad_sleep;
		sw_nxt      = meas && sbc_mode == WKD_NORMAL;
		for (int i = 0; i < 3; i++) begin
			unique case (pull_r[2*i +: 2])
				WKD_PULL_NONE: begin
					pu_nxt[i] = 1'b0;
					pd_nxt[i] = 1'b0;
				end
				WKD_PULL_DOWN: begin
					pu_nxt[i] = 1'b0;
					pd_nxt[i] = 1'b1;
				end
				WKD_PULL_UP: begin
					pu_nxt[i] = 1'b1;
					pd_nxt[i] = 1'b0;
				end
				WKD_PULL_AUTO: begin
					pu_nxt[i] = lvl[i];
					pd_nxt[i] = ~lvl[i];
				end
			endcase
			if (meas_gate[i]) begin
				pu_nxt[i] = 1'b0;
				pd_nxt[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r     <= 1'b0;
			wup_r     <= 1'b0;
			sfail_r   <= 1'b0;
			rst_req_r <= 1'b0;
			pu_r      <= 3'h0;
			pd_r      <= 3'h0;
			sw_r      <= 1'b0;
		end else begin
			irq_r     <= irq_nxt;
			wup_r     <= wup_nxt;
			sfail_r   <= sfail_nxt;
			rst_req_r <= rst_req_nxt;
			pu_r      <= pu_nxt;
			pd_r      <= pd_nxt;
			sw_r      <= sw_nxt;
		end
	end

	assign prdata               = prdata_r;
	assign pready               = pready_r;
	assign pslverr              = pslverr_r;
	assign wake_irq             = irq_r;
	assign wake_up_req          = wup_r;
	assign serial_fail_set      = sfail_r;
	assign restart_req          = rst_req_r;
	assign pull_up_en           = pu_r;
	assign pull_down_en         = pd_r;
	assign measure_switch_close = sw_r;

	default clocking wkd_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	apb_one_wait_a: assert property (psel && penable && !pready |=> pready)
		else $error("apb access not answered after one wait");
	src_sticky_a: assert property (src_r != 3'h0 && !(wr && paddr == WKD_OFF_SRC_STAT)
		|=> (src_r & $past(src_r)) == $past(src_r))
		else $error("wake source bit lost without clear");
	irq_mode_a: assert property (wake_irq |-> $past(mode_awake))
		else $error("interrupt outside normal or stop mode");
	wake_mode_a: assert property ($rose(src_r[1]) |-> wake_up_req == !$past(mode_awake))
		else $error("wake-up request does not follow mode");
	meas_switch_a: assert property (measure_switch_close == $past(meas && sbc_mode == WKD_NORMAL))
		else $error("measurement switch state wrong");
	meas_pull_off_a: assert property (meas [*2] |-> pull_up_en[1:0] == 2'h0 && pull_down_en[1:0] == 2'h0)
		else $error("pulls active on measured inputs");
	pull_excl_a: assert property ((pull_up_en & pull_down_en) == 3'h0)
		else $error("pull-up and pull-down both on");
	meas_gate_a: assert property ($rose(src_r[0]) || $rose(src_r[1]) |-> !$past(meas))
		else $error("gated input set its wake source");
	enable_gate_a: assert property ($rose(src_r[2]) |-> $past(wake_en[2]))
		else $error("disabled input set its wake source");
	alt_status_a: assert property ($rose(alt_r[0]) |-> $past(fo_en[0]) && $past(evt[3]))
		else $error("alternate status set without enabled fail-output event");
	sleep_fail_a: assert property (sleep_cmd && bad_sleep |=> serial_fail_set && restart_req)
		else $error("bad sleep command not flagged");
	auto_pull_a: assert property ((pull_r[5:4] == WKD_PULL_AUTO) [*2] |-> pull_up_en[2] == $past(lvl[2]))
		else $error("automatic pull does not follow level");

	irq_seen_c:   cover property (wake_irq);
	wake_seen_c:  cover property (wake_up_req);
	sfail_seen_c: cover property (serial_fail_set);
	cyc_lvl_c:    cover property (cyc[2] && lvl_r[2] != $past(lvl_r[2]));

endmodule // wkd_top
`default_nettype wire

// file: tb/wkd_pin_model.sv
// wkd_pin_model: switches and sensors outside the three wake pins and two fail-output pins.
// assumes the bench sets drive enables and levels on pclk; pull enables come from the design.
`timescale 1ns/1ps
`default_nettype none
module wkd_pin_model (
	input  wire logic       pclk,
	input  wire logic [2:0] drv_on,
	input  wire logic [2:0] drv_val,
	input  wire logic [1:0] fo_val,
	input  wire logic [2:0] pull_up_en,
	input  wire logic [2:0] pull_down_en,
	output var  logic [2:0] pins,
	output var  logic [1:0] fo_pins
);
	initial pins = 3'h0;
	initial fo_pins = 2'h0;
	// released pin follows its pull; with none it floats and wanders each cycle
	always @(posedge pclk) begin
		for (int i = 0; i < 3; i++) begin
			if (drv_on[i])
				pins[i] <= drv_val[i];
			else if (pull_up_en[i])
				pins[i] <= 1'b1;
			else if (pull_down_en[i])
				pins[i] <= 1'b0;
			else
				pins[i] <= ~pins[i];
		end
		fo_pins <= fo_val; // driven hard, never released
	end
endmodule // wkd_pin_model
`default_nettype wire

// file: tb/wkd_top_test.sv
// wkd_top_test: self-checking bench for the wake input detection block.
// assumes wkd_pkg, wkd_filt_if, wkd_filter, wkd_top and wkd_pin_model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module wkd_top_test
	import wkd_pkg::*;
;
	localparam int SC = 4; // shortened filter counts keep the run brief
	localparam int LC = 16;
	localparam logic [7:0] A_EN = WKD_OFF_WAKE_EN;
	localparam logic [7:0] A_PU = WKD_OFF_PULL;
	localparam logic [7:0] A_FT = WKD_OFF_FILT;
	localparam logic [7:0] A_SR = WKD_OFF_SRC_STAT;
	localparam logic [7:0] A_LV = WKD_OFF_LVL_STAT;
	typedef struct {
		logic        wr;
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] q;
		logic        e;
	} wkd_row_t;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [2:0]  drv_on = 3'h7;
	logic [2:0]  drv_val = 3'h0;
	logic [1:0]  fo_val = 2'h0;
	logic [2:0]  pins;
	logic [1:0]  fo_pins;
	wkd_mode_t   sbc_mode = WKD_NORMAL;
	logic        sleep_cmd = 1'b0;
	logic        timer_one_on = 1'b0;
	logic        timer_two_on = 1'b0;
	logic        wake_irq;
	logic        wake_up_req;
	logic        serial_fail_set;
	logic        restart_req;
	logic [2:0]  pull_up_en;
	logic [2:0]  pull_down_en;
	logic        measure_switch_close;
	int          err_total = 0;
	int          total_checks = 0;
	int          irq_cnt = 0;
	int          wup_cnt = 0;
	int          fail_cnt = 0;
	int          rst_cnt = 0;
	int          cyc = 0;
	// reset values, read-back, read-only and unmapped places
	wkd_row_t    rows [7] = '{
		'{1'b0, A_EN, 32'h0, 32'h0, 1'b0},
		'{1'b0, A_PU, 32'h0, 32'h0, 1'b0},
		'{1'b0, A_FT, 32'h0, 32'h0, 1'b0},
		'{1'b1, A_PU, 32'h3f, 32'h3f, 1'b0},
		'{1'b1, A_PU, 32'h0, 32'h0, 1'b0},
		'{1'b1, A_LV, 32'h7, 32'h0, 1'b0},
		'{1'b1, 8'h18, 32'h1, 32'h0, 1'b1}
	};

	always #12.5 pclk = ~pclk;

	wkd_top #(.SHORT_CYC(SC), .LONG_CYC(LC)) wkd_top_inst (
		.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.wake_input_one(pins[0]), .wake_input_two(pins[1]), .wake_input_three(pins[2]),
		.fail_outputs_two_three(fo_pins), .sbc_mode, .sleep_cmd, .timer_one_on, .timer_two_on,
		.wake_irq, .wake_up_req, .serial_fail_set, .restart_req, .pull_up_en, .pull_down_en,
		.measure_switch_close
	);
	wkd_pin_model wkd_pin_model_inst (
		.pclk, .drv_on, .drv_val, .fo_val, .pull_up_en, .pull_down_en, .pins, .fo_pins
	);

	// pulse counters and hang guard
	always @(posedge pclk) begin
		cyc++;
		if (wake_irq === 1'b1) irq_cnt++;
		if (wake_up_req === 1'b1) wup_cnt++;
		if (serial_fail_set === 1'b1) fail_cnt++;
		if (restart_req === 1'b1) rst_cnt++;
		if (cyc == 12000) begin
			err_total++;
			$display("mismatch run length expected end seen hang");
			finish_test();
		end
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_cnt(input string nm, input int exp, input int got);
		total_checks++;
		if (got != exp) begin
			err_total++;
			$display("mismatch %s expected %0d seen %0d", nm, exp, got);
		end
	endtask

	// one transfer; entered right after a rising edge, leaves one edge after release
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		int n;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		e = pslverr;
		chk_cnt("ready wait", 1, int'(n < 20));
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		chk("write error", 32'h0, {31'h0, e});
	endtask

	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk($sformatf("register %h", a), exp, q);
	endtask

	task automatic idle(input int n);
		repeat (n) @(posedge pclk);
	endtask

	task automatic pin(input int i, input logic v);
		drv_on[i] <= 1'b1;
		drv_val[i] <= v;
	endtask

	// no wake pulse of either kind for n cycles
	task automatic quiet(input int n);
		int b;
		b = irq_cnt + wup_cnt;
		idle(n);
		chk_cnt("pulse count", b, irq_cnt + wup_cnt);
	endtask

	// first pulse must be of the right kind and come no sooner than the filter time
	task automatic expect_pulse(input logic irq_exp, input int min);
		int lat;
		lat = 0;
		do begin
			@(posedge pclk);
			lat++;
		end while (wake_irq !== 1'b1 && wake_up_req !== 1'b1 && lat < 200);
		chk("irq pulse", {31'h0, irq_exp}, {31'h0, wake_irq});
		chk("wake pulse", {31'h0, ~irq_exp}, {31'h0, wake_up_req});
		chk_cnt("pulse latency", 1, int'(lat >= min && lat <= min + 8));
	endtask

	initial begin
		logic [31:0] q;
		logic        e;
		logic        lv;
		logic [1:0]  c;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("outputs after reset", 32'h0, {pull_up_en, pull_down_en, measure_switch_close});
		foreach (rows[k]) begin
			if (rows[k].wr) apb(1'b1, rows[k].a, rows[k].d, q, e);
			apb(1'b0, rows[k].a, 32'h0, q, e);
			chk("read data", rows[k].q, q);
			chk("read error", {31'h0, rows[k].e}, {31'h0, e});
		end
		// both edges on input one, sticky until written one
		reg_wr(A_EN, 32'h7);
		pin(0, 1'b1);
		expect_pulse(1'b1, SC);
		idle(5);
		reg_rd(A_SR, 32'h1);
		reg_wr(A_SR, 32'h1);
		reg_rd(A_SR, 32'h0);
		pin(0, 1'b0);
		expect_pulse(1'b1, SC);
		reg_wr(A_SR, 32'h1);
		// every mode: interrupt or wake-up, level readable in normal and stop
		for (int m = 0; m < 4; m++) begin
			sbc_mode <= wkd_mode_t'(m);
			pin(1, ~drv_val[1]);
			expect_pulse(m < 2, SC);
			reg_rd(A_SR, 32'h2);
			reg_wr(A_SR, 32'h2);
			if (m < 2) reg_rd(A_LV, {29'h0, drv_val});
		end
		sbc_mode <= WKD_NORMAL;
		reg_wr(A_FT, 32'h10);
		pin(2, 1'b1);
		expect_pulse(1'b1, LC);
		reg_wr(A_FT, 32'h0);
		reg_wr(A_SR, 32'h4);
		// glitch shorter than the filter is dropped
		pin(0, 1'b1);
		idle(2);
		pin(0, 1'b0);
		quiet(40);
		reg_rd(A_SR, 32'h0);
		// disabled input: level seen, no wake
		reg_wr(A_EN, 32'h6);
		pin(0, 1'b1);
		quiet(40);
		reg_rd(A_SR, 32'h0);
		reg_rd(A_LV, {29'h0, drv_val});
		// cyclic sense on each timer: nothing outside the window
		reg_wr(A_EN, 32'h1);
		for (int t = 2; t < 4; t++) begin
			reg_wr(A_FT, t);
			lv = drv_val[0];
			pin(0, ~lv);
			quiet(40);
			reg_rd(A_LV, {29'h0, drv_val[2:1], lv});
			timer_one_on <= (t == 2); // window stands for a timer also powering the sensor
			timer_two_on <= (t == 3);
			expect_pulse(1'b1, SC);
			reg_rd(A_LV, {29'h0, drv_val[2:1], ~lv});
			timer_one_on <= 1'b0;
			timer_two_on <= 1'b0;
			reg_wr(A_SR, 32'h1);
		end
		// fail-output pins report in the alternate status
		reg_wr(A_FT, 32'h0);
		reg_wr(A_EN, 32'h30);
		fo_val <= 2'h1;
		expect_pulse(1'b1, SC);
		fo_val <= 2'h3;
		expect_pulse(1'b1, SC);
		reg_rd(WKD_OFF_ALT_STAT, 32'h3);
		// measurement: switch, pulls off, frozen status, bad sleep command
		reg_wr(A_PU, 32'h2a);
		reg_wr(A_EN, 32'hb);
		drv_on <= 3'h4;
		idle(4);
		chk("switch closed", 32'h1, {31'h0, measure_switch_close});
		chk("pull up", 32'h4, {29'h0, pull_up_en});
		quiet(40);
		reg_rd(A_SR, 32'h0);
		reg_rd(A_LV, {29'h0, drv_val});
		sbc_mode <= WKD_STOP;
		idle(4);
		chk("switch open", 32'h0, {31'h0, measure_switch_close});
		for (int s = 0; s < 2; s++) begin
			sleep_cmd <= 1'b1;
			@(posedge pclk);
			sleep_cmd <= 1'b0;
			idle(4);
			chk_cnt("serial fail", 1, fail_cnt);
			chk_cnt("restart", 1, rst_cnt);
			reg_wr(A_EN, 32'hf);
		end
		sbc_mode <= WKD_NORMAL;
		reg_wr(A_EN, 32'h0);
		idle(4);
		chk("switch off", 32'h0, {31'h0, measure_switch_close});
		// every pull code, automatic following the level
		drv_on <= 3'h7;
		drv_val <= 3'h5;
		for (int p = 0; p < 4; p++) begin
			c = p;
			reg_wr(A_PU, {26'h0, c, c, c});
			idle(8);
			chk("pull up", {29'h0, {3{c == 2'h2}} | ({3{c == 2'h3}} & 3'h5)}, {29'h0, pull_up_en});
			chk("pull down", {29'h0, {3{c == 2'h1}} | ({3{c == 2'h3}} & 3'h2)}, {29'h0, pull_down_en});
		end
		// reset in mid-run clears pull settings and pull outputs
		presetn <= 1'b0;
		idle(2);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("pulls after reset", 32'h0, {26'h0, pull_up_en, pull_down_en});
		reg_rd(A_PU, 32'h0);
		finish_test();
	end
endmodule // wkd_top_test
`default_nettype wire
